// ### src/lsr_pkg.sv
// package for the light sensor status register block
// assumes a 10 MHz system clock and an 8-bit command code register port
package lsr_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam logic [7:0] CMD_POWER_SAVE = 8'h03;
    localparam logic [7:0] CMD_AMBIENT = 8'h04;
    localparam logic [7:0] CMD_WHITE = 8'h05;
    localparam logic [7:0] CMD_STATUS = 8'h06;
    localparam logic [7:0] CMD_IDENT = 8'h07;
    localparam int PS_ENABLE_BIT = 0;
    localparam int PS_MODE_LSB = 1;
    localparam int PS_MODE_MSB = 2;
    localparam int LOW_FLAG_BIT = 15;
    localparam int HIGH_FLAG_BIT = 14;
    localparam logic [2:0] PS_RESET = 3'h0;
    localparam logic [7:0] ADDR_OPT_A_CODE = 8'h20;
    localparam logic [7:0] ADDR_OPT_B_CODE = 8'h90;
    // idle time per mode in ms: refresh = integration + idle
    localparam int unsigned IDLE_MS_MODE1 = 500;
    localparam int unsigned IDLE_MS_MODE2 = 1000;
    localparam int unsigned IDLE_MS_MODE3 = 2000;
    localparam int unsigned IDLE_MS_MODE4 = 4000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    typedef enum logic [1:0] {
        LSR_MODE1 = 2'b00,
        LSR_MODE2 = 2'b01,
        LSR_MODE3 = 2'b10,
        LSR_MODE4 = 2'b11
    } lsr_mode_t;
endpackage : lsr_pkg

// ### src/lsr_refresh_if.sv
// interface between the register block and its refresh timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lsr_refresh_if;
    import lsr_pkg::*;
    logic enable;
    lsr_mode_t mode;
    logic [31:0] integ_cycles;
    logic tick;
    modport ctrl (output enable, output mode, output integ_cycles, input tick);
    modport timer (input enable, input mode, input integ_cycles, output tick);
endinterface : lsr_refresh_if

// ### src/lsr_refresh_timer.sv
// refresh timer for power saving operation
// assumes enable and mode come from registers on the same clock
`timescale 1ns/1ps
module lsr_refresh_timer #(
    parameter int unsigned MS_SCALE = lsr_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    lsr_refresh_if.timer rf
);
    import lsr_pkg::*;
    logic [31:0] count_reg;
    logic [31:0] idle_cycles;
    logic [31:0] period;

    always_comb begin
        unique case (rf.mode)
            LSR_MODE1: idle_cycles = 32'(IDLE_MS_MODE1 * MS_SCALE);
            LSR_MODE2: idle_cycles = 32'(IDLE_MS_MODE2 * MS_SCALE);
            LSR_MODE3: idle_cycles = 32'(IDLE_MS_MODE3 * MS_SCALE);
            LSR_MODE4: idle_cycles = 32'(IDLE_MS_MODE4 * MS_SCALE);
        endcase
        period = rf.integ_cycles + idle_cycles;
    end

    // counter restarts whenever power saving is off
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_reg <= 32'h0;
        end else if (!rf.enable || count_reg >= period - 32'h1) begin
            count_reg <= 32'h0;
        end else begin
            count_reg <= count_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rf.tick <= 1'b0;
        end else begin
            rf.tick <= rf.enable && (count_reg >= period - 32'h1);
        end
    end
endmodule : lsr_refresh_timer

// ### src/lsr_status_regs.sv
// register block: power saving, results, threshold flags, identity
// assumes the link front end gives one-cycle read and write strobes with a command code
`timescale 1ns/1ps
module lsr_status_regs #(
    parameter logic [7:0] DEVICE_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] OPT_A_ID = 8'h3c, // arbitrary value
    parameter logic [7:0] OPT_B_ID = 8'h3d, // arbitrary value
    parameter int unsigned MS_SCALE = lsr_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic wr_stb_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_stb_i,
    output logic [15:0] rd_data_o,
    input wire logic [7:0] bus_addr_option_i,
    input wire logic [15:0] ambient_result_value_i,
    input wire logic [15:0] white_result_i,
    input wire logic result_valid_i,
    input wire logic [15:0] high_window_i,
    input wire logic [15:0] low_window_i,
    input wire logic threshold_event_enable_i,
    input wire logic [31:0] integration_cycles_i,
    output logic power_save_enable_o,
    output lsr_pkg::lsr_mode_t power_save_mode_select_o,
    output logic refresh_o,
    output logic low_crossing_flag_o,
    output logic high_crossing_flag_o
);
    import lsr_pkg::*;

    // ----------------------------------------
    // power saving register
    // ----------------------------------------
    logic [2:0] ps_reg;
    lsr_refresh_if rf_bus ();

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ps_reg <= PS_RESET;
        end else if (wr_stb_i && cmd_code_i == CMD_POWER_SAVE) begin
            // upper bits are dropped, so a careless host cannot set them
            ps_reg <= wr_data_i[PS_MODE_MSB:PS_ENABLE_BIT];
        end
    end

    assign rf_bus.enable = ps_reg[PS_ENABLE_BIT];
    assign rf_bus.mode = lsr_mode_t'(ps_reg[PS_MODE_MSB:PS_MODE_LSB]);
    assign rf_bus.integ_cycles = integration_cycles_i;

    lsr_refresh_timer #(.MS_SCALE(MS_SCALE)) u_timer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .rf(rf_bus)
    );

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            power_save_enable_o <= 1'b0;
            power_save_mode_select_o <= LSR_MODE1;
            refresh_o <= 1'b0;
        end else begin
            power_save_enable_o <= ps_reg[PS_ENABLE_BIT];
            power_save_mode_select_o <= lsr_mode_t'(ps_reg[PS_MODE_MSB:PS_MODE_LSB]);
            refresh_o <= rf_bus.tick;
        end
    end

    // ----------------------------------------
    // threshold crossing flags
    // ----------------------------------------
    logic low_hit;
    logic high_hit;
    logic status_rd;
    logic low_flag_reg;
    logic high_flag_reg;

    // flags only arise on a fresh result while events are enabled
    assign low_hit = result_valid_i && threshold_event_enable_i
                     && ambient_result_value_i < low_window_i;
    assign high_hit = result_valid_i && threshold_event_enable_i
                      && ambient_result_value_i > high_window_i;
    assign status_rd = rd_stb_i && cmd_code_i == CMD_STATUS;

    // set wins over the clear from a status read in the same cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            low_flag_reg <= 1'b0;
        end else if (low_hit) begin
            low_flag_reg <= 1'b1;
        end else if (status_rd) begin
            low_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            high_flag_reg <= 1'b0;
        end else if (high_hit) begin
            high_flag_reg <= 1'b1;
        end else if (status_rd) begin
            high_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            low_crossing_flag_o <= 1'b0;
            high_crossing_flag_o <= 1'b0;
        end else begin
            low_crossing_flag_o <= low_flag_reg;
            high_crossing_flag_o <= high_flag_reg;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] opt_id;
    logic [15:0] rd_next;

    // address option outside the two known codes reads as option a
    assign opt_id = (bus_addr_option_i == ADDR_OPT_B_CODE) ? OPT_B_ID : OPT_A_ID;

    always_comb begin
        rd_next = 16'h0000;
        unique case (cmd_code_i)
            CMD_POWER_SAVE: rd_next = {13'h0000, ps_reg};
            CMD_AMBIENT: rd_next = ambient_result_value_i;
            CMD_WHITE: rd_next = white_result_i;
            CMD_STATUS: rd_next = {low_flag_reg, high_flag_reg, 14'h0000};
            CMD_IDENT: rd_next = {opt_id, DEVICE_ID};
            default: rd_next = 16'h0000;
        endcase
    end

    // read-only codes have no write path, so writes there are dropped
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_stb_i) begin
            rd_data_o <= rd_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ps_write_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_stb_i && cmd_code_i == CMD_POWER_SAVE |=> ##1
        power_save_mode_select_o == lsr_mode_t'($past(wr_data_i[2:1], 2)))
        else $error("mode select did not follow write");
    a_ps_enable_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_stb_i && cmd_code_i == CMD_POWER_SAVE |=> ##1 power_save_enable_o == $past(wr_data_i[0], 2))
        else $error("enable did not follow write");
    a_ambient_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && cmd_code_i == CMD_AMBIENT |=> rd_data_o == $past(ambient_result_value_i))
        else $error("ambient read wrong");
    a_white_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && cmd_code_i == CMD_WHITE |=> rd_data_o == $past(white_result_i))
        else $error("white read wrong");
    a_low_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        low_hit |=> ##1 low_crossing_flag_o)
        else $error("low flag not set");
    a_high_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        high_hit |=> ##1 high_crossing_flag_o)
        else $error("high flag not set");
    a_status_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && cmd_code_i == CMD_STATUS |=> rd_data_o[13:0] == 14'h0000)
        else $error("status reserved bits nonzero");
    a_ident_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && cmd_code_i == CMD_IDENT |=> rd_data_o[7:0] == DEVICE_ID)
        else $error("identity low byte wrong");
    a_no_flag_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !threshold_event_enable_i && !low_flag_reg && !status_rd |=> !low_flag_reg)
        else $error("flag set while events disabled");
    a_status_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        status_rd && !low_hit && !high_hit |=> !low_flag_reg && !high_flag_reg)
        else $error("status read did not clear flags");
    a_high_no_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !threshold_event_enable_i && !high_flag_reg && !status_rd |=> !high_flag_reg)
        else $error("high flag set while events disabled");
    a_ps_reserved_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && cmd_code_i == CMD_POWER_SAVE |=> rd_data_o[15:3] == 13'h0000)
        else $error("power saving reserved bits nonzero");
    a_ident_opt_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && cmd_code_i == CMD_IDENT && bus_addr_option_i == ADDR_OPT_A_CODE
        |=> rd_data_o[15:8] == OPT_A_ID)
        else $error("identity high byte wrong for option a");
    a_ident_opt_b: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && cmd_code_i == CMD_IDENT && bus_addr_option_i == ADDR_OPT_B_CODE
        |=> rd_data_o[15:8] == OPT_B_ID)
        else $error("identity high byte wrong for option b");
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_stb_i && (cmd_code_i < CMD_POWER_SAVE || cmd_code_i > CMD_IDENT) |=> rd_data_o == 16'h0000)
        else $error("unmapped code read nonzero");
    a_ro_write_ignored: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_stb_i && cmd_code_i != CMD_POWER_SAVE |=> $stable(ps_reg))
        else $error("write to read-only code changed power saving");
    a_read_data_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !rd_stb_i |=> $stable(rd_data_o))
        else $error("read data moved without a read");
    a_refresh_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ps_reg[PS_ENABLE_BIT] |=> ##1 !refresh_o)
        else $error("refresh pulse while power saving off");
    a_refresh_single: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        refresh_o |=> !refresh_o)
        else $error("refresh pulse longer than one cycle");
endmodule : lsr_status_regs

// ### bench/lsr_front_model.sv
// measurement front end model: results and a valid pulse
// assumes a one-cycle go pulse from the bench on the same clock
`timescale 1ns/1ps
module lsr_front_model #(
    parameter int LAG = 3
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic go_i,
    input wire logic [15:0] amb_i,
    input wire logic [15:0] wht_i,
    output logic [15:0] amb_o,
    output logic [15:0] wht_o,
    output logic valid_o
);
    int cnt;
    // results only move with the pulse, as a converter would
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
            valid_o <= 1'b0;
            amb_o <= 16'h0;
            wht_o <= 16'h0;
        end else begin
            valid_o <= (cnt == 1);
            cnt <= go_i ? LAG : (cnt > 0 ? cnt - 1 : 0);
            if (cnt == 1) begin
                amb_o <= amb_i;
                wht_o <= wht_i;
            end
        end
    end
endmodule : lsr_front_model

// ### bench/lsr_status_regs_test.sv
// testbench for the light sensor status register block
// assumes src files and the front end model are compiled first
`timescale 1ns/1ps
module lsr_status_regs_test;
    import lsr_pkg::*;
    localparam logic [7:0] DID = 8'ha5; // arbitrary value
    localparam logic [7:0] IDA = 8'h11; // arbitrary value
    localparam logic [7:0] IDB = 8'h22; // arbitrary value
    logic clk_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, rdq = 1'b0, go = 1'b0, ev_en = 1'b0;
    logic [7:0] cmd = 8'h0, opt = 8'h20;
    logic [15:0] wd = 16'h0, amb = 16'h0, wht = 16'h0, rd, rdo, amb_r, wht_r;
    logic [31:0] integ = 32'h14;
    logic valid, ps_en, refresh, lo_f, hi_f;
    lsr_mode_t mode;
    int err_total = 0, checks = 0, cyc = 0, p;
    initial forever #50 clk_i = ~clk_i;
    lsr_front_model #(.LAG(3)) i_front (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .amb_i(amb),
        .wht_i(wht), .amb_o(amb_r), .wht_o(wht_r), .valid_o(valid));
    lsr_status_regs #(.DEVICE_ID(DID), .OPT_A_ID(IDA), .OPT_B_ID(IDB), .MS_SCALE(1)) i_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_code_i(cmd), .wr_stb_i(wr), .wr_data_i(wd),
        .rd_stb_i(rdq), .rd_data_o(rdo), .bus_addr_option_i(opt), .ambient_result_value_i(amb_r),
        .white_result_i(wht_r), .result_valid_i(valid), .high_window_i(16'hf000), .low_window_i(16'h0100),
        .threshold_event_enable_i(ev_en), .integration_cycles_i(integ), .power_save_enable_o(ps_en),
        .power_save_mode_select_o(mode), .refresh_o(refresh), .low_crossing_flag_o(lo_f),
        .high_crossing_flag_o(hi_f));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_i);
        {wr, cmd, wd} <= {1'b1, c, d};
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] c);
        @(posedge clk_i);
        {rdq, cmd} <= {1'b1, c};
        @(posedge clk_i);
        rdq <= 1'b0;
        @(posedge clk_i);
        #1 rd = rdo;
    endtask : rd_reg
    // waits on the model's valid, then lets the flag outputs settle
    task automatic measure(input logic [15:0] a);
        @(posedge clk_i);
        {go, amb, wht} <= {1'b1, a, ~a};
        @(posedge clk_i);
        go <= 1'b0;
        for (int i = 0; i < 20 && valid !== 1'b1; i++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        #1;
    endtask : measure
    task automatic pulse_gap(output int g);
        int a;
        do @(posedge clk_i); while (refresh !== 1'b1);
        a = cyc;
        do @(posedge clk_i); while (refresh !== 1'b1);
        g = cyc - a;
    endtask : pulse_gap
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    // hang guard, well above the roughly 17000 cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_reg(CMD_POWER_SAVE);
        check("ps reset", rd, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            wr_reg(CMD_POWER_SAVE, 16'(m * 2 + 1));
            rd_reg(CMD_POWER_SAVE);
            check("ps read", rd, 16'(m * 2 + 1));
            check("ps pins", {13'h0, mode, ps_en}, 16'(m * 2 + 1));
        end
        wr_reg(CMD_POWER_SAVE, 16'h0004);
        for (logic [7:0] c = CMD_AMBIENT; c <= CMD_IDENT; c++) wr_reg(c, 16'hffff);
        rd_reg(CMD_POWER_SAVE);
        check("ro write", rd, 16'h0004);
        check("ps off", {15'h0, ps_en}, 16'h0000);
        $display("power save test done");
        measure(16'h0050);
        rd_reg(CMD_STATUS);
        check("flags off", rd, 16'h0000);
        rd_reg(CMD_AMBIENT);
        check("ambient", rd, 16'h0050);
        rd_reg(CMD_WHITE);
        check("white", rd, 16'hffaf);
        @(posedge clk_i);
        ev_en <= 1'b1;
        measure(16'h0050);
        check("low pin", {15'h0, lo_f}, 16'h0001);
        rd_reg(CMD_STATUS);
        check("low flag", rd, 16'h8000);
        rd_reg(CMD_STATUS);
        check("cleared", rd, 16'h0000);
        check("low pin clr", {15'h0, lo_f}, 16'h0000);
        measure(16'hf800);
        check("high pin", {15'h0, hi_f}, 16'h0001);
        wr_reg(CMD_STATUS, 16'h0000);
        rd_reg(CMD_STATUS);
        check("high flag", rd, 16'h4000);
        check("high pin clr", {15'h0, hi_f}, 16'h0000);
        $display("status test done");
        rd_reg(CMD_IDENT);
        check("ident a", rd, {IDA, DID});
        @(posedge clk_i);
        opt <= 8'h90;
        rd_reg(CMD_IDENT);
        check("ident b", rd, {IDB, DID});
        rd_reg(8'h08);
        check("unmapped", rd, 16'h0000);
        $display("ident test done");
        wr_reg(CMD_POWER_SAVE, 16'h0001);
        pulse_gap(p);
        check("period m1", 16'(p), 16'(integ + IDLE_MS_MODE1));
        wr_reg(CMD_POWER_SAVE, 16'h0003);
        pulse_gap(p);
        check("period m2", 16'(p), 16'(integ + IDLE_MS_MODE2));
        wr_reg(CMD_POWER_SAVE, 16'h0005);
        pulse_gap(p);
        check("period m3", 16'(p), 16'(integ + IDLE_MS_MODE3));
        wr_reg(CMD_POWER_SAVE, 16'h0007);
        pulse_gap(p);
        check("period m4", 16'(p), 16'(integ + IDLE_MS_MODE4));
        wr_reg(CMD_POWER_SAVE, 16'h0000);
        repeat (3) @(posedge clk_i);
        p = 0;
        repeat (1100) @(posedge clk_i) p += (refresh === 1'b1);
        check("no refresh", 16'(p), 16'h0000);
        $display("refresh test done");
        give_verdict();
    end
endmodule : lsr_status_regs_test
